// *** core/bus_buffer_pkg.sv ***
// Purpose: shared constants for the hot swap two-wire bus buffer
// Assumes: 40 MHz system clock
// Notes:   idle time is a typical figure, counted in whole cycles
package bus_buffer_pkg;
  localparam int  CLK_MHZ        = 40;
  // idle time before connecting, in microseconds
  localparam int  IDLE_TIME_US   = 95;
  localparam int  IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;
  localparam int  CNT_W          = 13;
  // power-up lockout length in cycles
  localparam int  LOCKOUT_CYCLES = 16;
  localparam int  LOCK_W         = 5;
  // reset value of a two-wire line is released (high)
  localparam logic LINE_RST      = 1'b1;
  // position of each channel in a two-bit line vector
  localparam int  CH_CLK         = 0;
  localparam int  CH_DATA        = 1;
  localparam int  NUM_CH         = 2;
endpackage : bus_buffer_pkg

// *** core/buffer_channel.sv ***
// Purpose: one bidirectional open-drain buffer channel
// Assumes: line inputs synchronised, own pull echo already removed
// Notes:   the side that went low first keeps control until it lets go
`timescale 1ns/10ps
module buffer_channel (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // connection control
  input  wire logic connected,
  // synchronised line levels
  input  wire logic backIn,
  input  wire logic cardIn,
  // pull-down enables
  output logic      backPull,
  output logic      cardPull
);
  typedef enum logic [1:0] {IDLE, BACK_CTRL, CARD_CTRL} ctrl_t;
  ctrl_t ctrl;

  // own pull masked for the cycles before its echo is removed upstream
  logic backExt;
  logic cardExt;
  assign backExt = !backIn && !backPull;
  assign cardExt = !cardIn && !cardPull;

  // direction tracking; same response in both directions except a tie in IDLE, where back wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= IDLE;
    end else if (!connected) begin
      ctrl <= IDLE; // isolated, paths inactive
    end else begin
      case (ctrl)
        IDLE: begin
          if (backExt) ctrl <= BACK_CTRL;
          else if (cardExt) ctrl <= CARD_CTRL;
        end
        // release of the driver ends its control; the other side
        // taking over comes from its own external drive
        BACK_CTRL: begin
          if (backIn) ctrl <= cardExt ? CARD_CTRL : IDLE;
        end
        CARD_CTRL: begin
          if (cardIn) ctrl <= backExt ? BACK_CTRL : IDLE;
        end
        default: ctrl <= IDLE;
      endcase
    end
  end

  // drive the opposite side low while one side is held
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      backPull <= 1'b0;
      cardPull <= 1'b0;
    end else begin
      cardPull <= connected && (ctrl == BACK_CTRL) && !backIn;
      backPull <= connected && (ctrl == CARD_CTRL) && !cardIn;
    end
  end
endmodule : buffer_channel

// *** core/hot_swap_buffer.sv ***
// Purpose: hot swap two-wire bus buffer with connect qualification
// Assumes: one 40 MHz clock; pins are open-drain, high when released
// Notes:   synchronous model of an analog buffer, adds a few cycles
//          control passes only after the own pull has drained, so a
//          handover shows a short high pulse on the released side
`timescale 1ns/10ps
module hot_swap_buffer #(
  parameter int IDLE_CYCLES = bus_buffer_pkg::IDLE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // enable pin
  input  wire logic       enable,
  // backplane side lines, bit 0 clock, bit 1 data
  input  wire logic [1:0] backLineIn,
  output logic      [1:0] backLineOut,
  output logic      [1:0] backLineOe,
  // card side lines
  input  wire logic [1:0] cardLineIn,
  output logic      [1:0] cardLineOut,
  output logic      [1:0] cardLineOe,
  // open-collector ready
  output logic            readyOut,
  output logic            readyOe
);
  typedef enum logic [1:0] {LOCKOUT, STANDBY, WAITING, LINKED} link_t;
  link_t linkState;

  // pin synchronisers, two flops each
  logic [1:0] backMeta;
  logic [1:0] backSync;
  logic [1:0] cardMeta;
  logic [1:0] cardSync;
  logic       enMeta;
  logic       enSync;
  // own pull as it comes back through the synchronisers
  logic [1:0] backEcho1;
  logic [1:0] backEcho2;
  logic [1:0] cardEcho1;
  logic [1:0] cardEcho2;
  // line levels with the device's own pull removed
  logic [1:0] backSeen;
  logic [1:0] cardSeen;
  // stop and idle qualification
  logic       prevBackData;
  logic [bus_buffer_pkg::CNT_W-1:0]  idleCnt;
  logic [bus_buffer_pkg::LOCK_W-1:0] lockCnt;
  logic       stopSeen;
  logic       allIdle;
  logic       idleDone;
  // channel pulls and link status
  logic [1:0] backPull;
  logic [1:0] cardPull;
  logic       connected;

  // a pair of lines is released when both read high
  function automatic logic lines_released(input logic [1:0] lines);
    return &lines;
  endfunction : lines_released

  // two-stage synchronisers on every pin input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      backMeta <= {2{bus_buffer_pkg::LINE_RST}};
      backSync <= {2{bus_buffer_pkg::LINE_RST}};
      cardMeta <= {2{bus_buffer_pkg::LINE_RST}};
      cardSync <= {2{bus_buffer_pkg::LINE_RST}};
      enMeta   <= 1'b0;
      enSync   <= 1'b0;
    end else begin
      backMeta <= backLineIn;
      backSync <= backMeta;
      cardMeta <= cardLineIn;
      cardSync <= cardMeta;
      enMeta   <= enable;
      enSync   <= enMeta;
    end
  end

  // the own pull reaches the synchronised level three cycles after the
  // channel asks for it (pull, output flop, two sync flops); delaying
  // the output enables by two flops lines the echo up with it, so a
  // line held only by this device never reads as external drive
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      backEcho1 <= 2'h0;
      backEcho2 <= 2'h0;
      cardEcho1 <= 2'h0;
      cardEcho2 <= 2'h0;
    end else begin
      backEcho1 <= backLineOe;
      backEcho2 <= backEcho1;
      cardEcho1 <= cardLineOe;
      cardEcho2 <= cardEcho1;
    end
  end

  // hides external drive under the own pull; logic levels cannot tell
  // which side is lower while both are low, unlike a voltage compare
  assign backSeen = backSync | backEcho2;
  assign cardSeen = cardSync | cardEcho2;

  // data edge history for stop detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) prevBackData <= bus_buffer_pkg::LINE_RST;
    else         prevBackData <= backSync[bus_buffer_pkg::CH_DATA];
  end

  // stop: data rises while clock high, backplane only
  assign stopSeen = backSync[bus_buffer_pkg::CH_DATA] && !prevBackData
                    && backSync[bus_buffer_pkg::CH_CLK]
                    && lines_released(cardSync); // card idle
  // idle: all lines released; card lines included as stated
  assign allIdle  = lines_released(backSync) && lines_released(cardSync);
  assign idleDone = (idleCnt >= IDLE_CYCLES[bus_buffer_pkg::CNT_W-1:0] - 1'b1)
                    && allIdle;

  // idle time counted in clock cycles
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      idleCnt <= '0;
    end else if (linkState != WAITING || !allIdle) begin
      idleCnt <= '0;
    end else if (!idleDone) begin
      idleCnt <= idleCnt + 1'b1;
    end
  end

  // power-up lockout length
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockCnt <= '0;
    end else if (linkState == LOCKOUT) begin
      lockCnt <= lockCnt + 1'b1;
    end
  end

  // connection sequencing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      linkState <= LOCKOUT;
    end else begin
      case (linkState)
        // bus activity ignored here
        LOCKOUT: begin
          if (lockCnt == bus_buffer_pkg::LOCK_W'(
                bus_buffer_pkg::LOCKOUT_CYCLES - 1))
            linkState <= STANDBY;
        end
        STANDBY: begin
          if (enSync) linkState <= WAITING;
        end
        // stay isolated until stop or idle
        WAITING: begin
          if (!enSync) linkState <= STANDBY;
          else if (stopSeen || idleDone) linkState <= LINKED;
        end
        // dropping enable isolates at once
        LINKED: begin
          if (!enSync) linkState <= STANDBY;
        end
        default: linkState <= LOCKOUT;
      endcase
    end
  end

  assign connected = (linkState == LINKED);

  // one identical channel per line
  for (genvar ch = 0; ch < bus_buffer_pkg::NUM_CH; ch++) begin : g_ch
    buffer_channel u_channel (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .connected (connected),
      .backIn    (backSeen[ch]),
      .cardIn    (cardSeen[ch]),
      .backPull  (backPull[ch]),
      .cardPull  (cardPull[ch])
    );
  end

  // open-drain outputs: drive low only, enable high while pulling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      backLineOut <= 2'h0;
      cardLineOut <= 2'h0;
    end else begin
      backLineOut <= 2'h0;
      cardLineOut <= 2'h0;
    end
  end

  // pull enables follow channels; extra register keeps outputs on flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      backLineOe <= 2'h0;
      cardLineOe <= 2'h0;
    end else begin
      backLineOe <= backPull;
      cardLineOe <= cardPull;
    end
  end

  // ready sinks until linked, then released to pull-up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readyOut <= 1'b0;
      readyOe  <= 1'b1;
    end else begin
      readyOut <= 1'b0;
      readyOe  <= !connected;
    end
  end
endmodule : hot_swap_buffer

// *** testbench/bus_agents.sv ***
// Purpose: backplane and card agents on open-drain wires
// Assumes: pull-ups on every line
// Notes:   wire-and of device and agent pulls, no delay
`timescale 1ns/10ps
module bus_agents (
  // device and agent pull-downs
  input  wire logic [1:0] backOe,
  input  wire logic [1:0] cardOe,
  input  wire logic [1:0] backDrive,
  input  wire logic [1:0] cardDrive,
  // resolved levels
  output logic      [1:0] backWire,
  output logic      [1:0] cardWire
);
  // a line is high only when nobody sinks it
  assign backWire = ~(backOe | backDrive);
  assign cardWire = ~(cardOe | cardDrive);
endmodule : bus_agents

// *** testbench/hot_swap_buffer_asserts.sv ***
// Purpose: port checks for the hot swap bus buffer
// Assumes: one clock, async active-high reset
// Notes:   bounds allow the few cycles of the pin pipeline
`timescale 1ns/10ps
module hot_swap_buffer_asserts #(
  parameter int IDLE_CYCLES = 20
) (
  // clock, reset, enable
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       enable,
  // line pins
  input wire logic [1:0] backLineIn,
  input wire logic [1:0] backLineOut,
  input wire logic [1:0] backLineOe,
  input wire logic [1:0] cardLineIn,
  input wire logic [1:0] cardLineOut,
  input wire logic [1:0] cardLineOe,
  // ready pin
  input wire logic       readyOut,
  input wire logic       readyOe
);
  int upCnt;
  int idleCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // time since reset, and length of the enabled idle stretch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      upCnt   <= 0;
      idleCnt <= 0;
    end else begin
      upCnt   <= (upCnt < 40) ? upCnt + 1 : upCnt;
      idleCnt <= (enable && &{backLineIn, cardLineIn}) ? idleCnt + 1 : 0;
    end
  end
  out_zero_a: assert property (backLineOut == 2'h0 &&
    cardLineOut == 2'h0 && !readyOut) else $error("pin level not low");
  lock_hold_a: assert property ($past(sys_rst) |-> (readyOe &&
    backLineOe == 2'h0 && cardLineOe == 2'h0) [*8]) else $error("lockout");
  dis_ready_a: assert property (!enable [*6] |-> readyOe)
    else $error("ready released while disabled");
  iso_pull_a: assert property (readyOe [*4] |-> backLineOe == 2'h0 &&
    cardLineOe == 2'h0) else $error("pull while isolated");
  one_side_a: assert property ((backLineOe & cardLineOe) == 2'h0)
    else $error("both sides pulled");
  clk_follow_a: assert property (enable && !readyOe && !backLineIn[0] &&
    !backLineOe[0] |-> ##[1:6] (cardLineOe[0] || backLineIn[0] || !enable))
    else $error("card clock not driven");
  data_follow_a: assert property (enable && !readyOe && !cardLineIn[1] &&
    !cardLineOe[1] |-> ##[1:6] (backLineOe[1] || cardLineIn[1] || !enable))
    else $error("back data not driven");
  pull_free_a: assert property (cardLineOe[1] && backLineIn[1]
    |-> ##[1:6] !cardLineOe[1]) else $error("card pull held");
  stop_conn_a: assert property ((enable && upCnt >= 30) [*6] ##0
    ($rose(backLineIn[1]) && backLineIn[0] && cardLineIn == 2'h3)
    |-> ##[1:6] !readyOe) else $error("no connect on stop");
  idle_conn_a: assert property (idleCnt >= IDLE_CYCLES + 30 |-> !readyOe)
    else $error("no connect on idle");
endmodule : hot_swap_buffer_asserts

// *** testbench/hot_swap_buffer_test.sv ***
// Purpose: directed scenarios for the hot swap bus buffer
// Assumes: 40 MHz clock, idle time shortened to 20 cycles
// Notes:   agents pull lines low through the wire model
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin \
  num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module hot_swap_buffer_test;
  localparam int IDLE = 20;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       enable = 1'b1;
  logic [1:0] bDrv = 2'h2;
  logic [1:0] cDrv = 2'h0;
  logic [1:0] bIn, cIn, bOe, cOe;
  logic       rdy;
  int         num_errors = 0;
  int         num_checks = 0;
  always #12.5 clk = ~clk;
  hot_swap_buffer #(.IDLE_CYCLES(IDLE)) DUT (.clk(clk), .sys_rst(sys_rst),
    .enable(enable), .backLineIn(bIn), .backLineOut(), .backLineOe(bOe),
    .cardLineIn(cIn), .cardLineOut(), .cardLineOe(cOe), .readyOut(),
    .readyOe(rdy));
  bus_agents AGT (.backOe(bOe), .cardOe(cOe), .backDrive(bDrv),
    .cardDrive(cDrv), .backWire(bIn), .cardWire(cIn));
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task close_out;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // backplane clock toggles, data held low: never a safe point
  task t_busy;
    repeat (30) begin
      bDrv[0] = ~bDrv[0];
      step(2);
      `CHK("rdyBusy", 1'b1, rdy)
      `CHK("cardIso", 2'h0, cOe)
    end
  endtask : t_busy
  // a stop counts only with the card lines idle
  task t_stop;
    cDrv = 2'h1;
    step(4);
    bDrv = 2'h0;
    step(10);
    `CHK("rdyCardBusy", 1'b1, rdy)
    bDrv = 2'h2;
    cDrv = 2'h0;
    step(4);
    bDrv = 2'h0;
    step(8);
    `CHK("rdyStop", 1'b0, rdy)
  endtask : t_stop
  // each channel, both directions
  task t_prop;
    for (int i = 0; i < 2; i++) begin
      bDrv[i] = 1'b1;
      step(8);
      `CHK("cardFollow", 1'b0, cIn[i])
      bDrv[i] = 1'b0;
      step(8);
      `CHK("cardFree", 2'h3, cIn)
      cDrv[i] = 1'b1;
      step(8);
      `CHK("backFollow", 1'b0, bIn[i])
      cDrv[i] = 1'b0;
      step(8);
      `CHK("backFree", 2'h3, bIn)
    end
  endtask : t_prop
  // control passes when the first side lets go
  task t_hand;
    bDrv[0] = 1'b1;
    step(8);
    cDrv[0] = 1'b1;
    step(4);
    bDrv[0] = 1'b0;
    step(12);
    `CHK("handBack", 2'h1, bOe)
    `CHK("handCard", 2'h0, cOe)
    cDrv[0] = 1'b0;
    step(8);
  endtask : t_hand
  // disable on an idle bus, then reconnect on idle time
  task t_off;
    enable = 1'b0; // bus is idle here
    step(8);
    `CHK("rdyOff", 1'b1, rdy)
    bDrv = 2'h3;
    step(8);
    `CHK("offIso", 2'h0, cOe)
    bDrv = 2'h0;
    enable = 1'b1;
    step(IDLE + 34); // long enough for the idle checker to see it
    `CHK("rdyIdle", 1'b0, rdy)
  endtask : t_off
  initial begin
    step(6);
    sys_rst = 1'b0;
    t_busy;
    t_stop;
    t_prop;
    t_hand;
    t_off;
    close_out;
  end
  // watchdog: the scenarios need well under 2000 cycles
  initial begin
    #(25 * 2000);
    num_errors++;
    close_out;
  end
endmodule : hot_swap_buffer_test
bind hot_swap_buffer hot_swap_buffer_asserts #(.IDLE_CYCLES(IDLE_CYCLES))
  CHKR (.clk(clk), .sys_rst(sys_rst), .enable(enable),
  .backLineIn(backLineIn), .backLineOut(backLineOut), .backLineOe(backLineOe),
  .cardLineIn(cardLineIn), .cardLineOut(cardLineOut), .cardLineOe(cardLineOe),
  .readyOut(readyOut), .readyOe(readyOe));
